// *** verification/fbp_array_model.sv ***
// behavioural array: boot image words and program/erase completion
`timescale 1ns/1ns
`default_nettype none
module fbp_array_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        slow,
    input  wire logic        arr_prog,
    input  wire logic        arr_erase,
    input  wire logic        arr_abort,
    input  wire logic        arr_rd_en,
    input  wire logic [8:0]  arr_rd_addr,
    output var  logic        arr_op_done,
    output var  logic [15:0] arr_rd_data
);
    // ------
    // array timing
    // ------
    logic [7:0] cnt_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r       <= 8'h00;
            arr_op_done <= 1'b0;
            arr_rd_data <= 16'hFFFF;
        end else begin
            // idle data toggles so a late sample never matches by luck
            arr_rd_data <= arr_rd_en ? {~arr_rd_addr[6:0], arr_rd_addr} : ~arr_rd_data;
            arr_op_done <= 1'b0;
            if (!(arr_prog || arr_erase) || arr_abort || arr_op_done) begin
                cnt_r <= 8'h00;
            end else if (cnt_r == (slow ? 8'h3C : 8'h03)) begin
                arr_op_done <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end
endmodule : fbp_array_model
`default_nettype wire

// *** verification/fbp_top_tb_top.sv ***
// self-checking bench for the block lock protection
`timescale 1ns/1ns
`default_nettype none
module fbp_top_tb_top;
    localparam int          NB     = 8;
    localparam logic [31:0] BOOTED = 32'h1 << fbp_pkg::FBP_CS_BOOT;
    localparam logic [31:0] REFD   = 32'h1 << fbp_pkg::FBP_CS_REFUSED;
    logic               clk, rstn, hardware_reset_n, hsel, hwrite, slow, hreadyout, hresp;
    logic               arr_prog, arr_erase, arr_abort, arr_op_done, arr_rd_en, boot_we;
    logic [31:0]        haddr, hwdata, hrdata;
    logic [1:0]         htrans;
    logic [2:0]         hsize, arr_blk;
    logic [8:0]         arr_rd_addr, boot_addr;
    logic [15:0]        arr_rd_data, boot_wdata;
    logic [31:0]        rd_q[$], bt_q[$], op_q[$];
    int                 n_errors, checks_done, seed, b, c, fb;
    logic               rd_ph = 1'b0, prev_op = 1'b0;
    fbp_pkg::fbp_lock_t lk[NB];
    logic [15:0]        cmds[5] = '{fbp_pkg::FBP_CMD_LOCK, fbp_pkg::FBP_CMD_TIGHT,
        fbp_pkg::FBP_CMD_UNLOCK, fbp_pkg::FBP_CMD_PROG, fbp_pkg::FBP_CMD_ERASE};

    fbp_top #(.NUM_BLOCKS(NB)) dut (.clk(clk), .rstn(rstn), .hardware_reset_n(hardware_reset_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .arr_prog(arr_prog), .arr_erase(arr_erase), .arr_blk(arr_blk),
        .arr_abort(arr_abort), .arr_op_done(arr_op_done), .arr_rd_en(arr_rd_en),
        .arr_rd_addr(arr_rd_addr), .arr_rd_data(arr_rd_data), .boot_we(boot_we),
        .boot_addr(boot_addr), .boot_wdata(boot_wdata));
    fbp_array_model arr (.clk(clk), .rstn(rstn), .slow(slow), .arr_prog(arr_prog),
        .arr_erase(arr_erase), .arr_abort(arr_abort), .arr_rd_en(arr_rd_en),
        .arr_rd_addr(arr_rd_addr), .arr_op_done(arr_op_done), .arr_rd_data(arr_rd_data));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ------
    // checking
    // ------
    task automatic tally(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask : tally
    task automatic cmp_rd();
        tally("hrdata", rd_q.size() ? rd_q.pop_front() : 32'hX, hrdata);
        tally("hresp", 32'h0, {31'h0, hresp});
    endtask : cmp_rd
    task automatic cmp_boot();
        tally("boot write", bt_q.size() ? bt_q.pop_front() : 32'hX, {7'h0, boot_addr, boot_wdata});
    endtask : cmp_boot
    task automatic cmp_op();
        tally("array op", op_q.size() ? op_q.pop_front() : 32'hX,
              {26'h0, arr_abort, arr_prog, arr_erase, arr_abort ? 3'h0 : arr_blk});
    endtask : cmp_op
    // outputs settle well before the falling edge, so sampling there avoids races
    always @(negedge clk) begin
        if (rd_ph) cmp_rd();
        if (boot_we) cmp_boot();
        if (((arr_prog || arr_erase) && !prev_op) || arr_abort) cmp_op();
        rd_ph   = rstn && hsel && htrans[1] && !hwrite;
        prev_op = arr_prog || arr_erase;
    end
    // ------
    // bus and commands
    // ------
    task automatic ahb(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {14'h0, idx, 2'h0};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0, wd};
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask : ahb
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        if (idx == fbp_pkg::FBP_IDX_FBN) fb = d;
        ahb(1'b1, idx, d);
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [31:0] e);
        rd_q.push_back(e);
        ahb(1'b0, idx, 16'h0000);
    endtask : rd
    function automatic logic [31:0] wps(input fbp_pkg::fbp_lock_t s);
        return {29'h0, s == fbp_pkg::FBP_UNLOCKED ? fbp_pkg::FBP_WPS_OPEN :
                s == fbp_pkg::FBP_TIGHT ? fbp_pkg::FBP_WPS_SEALED : fbp_pkg::FBP_WPS_CLOSED};
    endfunction : wps
    task automatic issue(input int blk, input logic [15:0] k);
        logic op, ok;
        op = k == fbp_pkg::FBP_CMD_PROG || k == fbp_pkg::FBP_CMD_ERASE;
        ok = lk[blk] == fbp_pkg::FBP_UNLOCKED;
        if (op && ok) op_q.push_back({27'h0, k == fbp_pkg::FBP_CMD_PROG,
                                      k == fbp_pkg::FBP_CMD_ERASE, 3'(blk)});
        wr(fbp_pkg::FBP_IDX_TBN, 16'(blk));
        wr(fbp_pkg::FBP_IDX_CMD, k);
        case (k)
            fbp_pkg::FBP_CMD_LOCK:
                if (lk[blk] != fbp_pkg::FBP_TIGHT) lk[blk] = fbp_pkg::FBP_LOCKED;
            fbp_pkg::FBP_CMD_TIGHT: if (!ok) lk[blk] = fbp_pkg::FBP_TIGHT;
            fbp_pkg::FBP_CMD_UNLOCK:
                if (lk[blk] == fbp_pkg::FBP_LOCKED) lk[blk] = fbp_pkg::FBP_UNLOCKED;
            default: ;
        endcase
        if (op) begin
            @(negedge clk);
            for (int i = 0; i < 300 && (arr_prog || arr_erase); i++) @(negedge clk);
            rd(fbp_pkg::FBP_IDX_CTRL, ok ? BOOTED : BOOTED | REFD);
        end else begin
            // status follows a lock command without a fresh block number write
            rd(fbp_pkg::FBP_IDX_WPS, wps(lk[fb]));
        end
    endtask : issue
    task automatic warm();
        @(posedge clk);
        hardware_reset_n <= 1'b0;
        repeat (8) @(posedge clk);
        hardware_reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        for (int i = 0; i < NB; i++) lk[i] = fbp_pkg::FBP_LOCKED;
        fb = 0;
    endtask : warm
    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    // ------
    // scenarios
    // ------
    initial begin
        seed = 1233;
        {rstn, hsel, hwrite, slow, htrans, haddr, hwdata} = '0;
        hardware_reset_n = 1'b1;
        hsize = 3'h2;
        for (int i = 0; i < NB; i++) lk[i] = fbp_pkg::FBP_LOCKED;
        for (int a = 0; a < 512; a++) bt_q.push_back({7'h0, 9'(a), ~7'(a), 9'(a)});
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 2000 && bt_q.size() > 0; i++) @(posedge clk);
        rd(fbp_pkg::FBP_IDX_CTRL, BOOTED);
        rd(fbp_pkg::FBP_IDX_WPS, 32'h2);
        rd(16'hF300, 32'h0);
        wr(16'h0000, 16'h1234);
        hsize <= 3'h1;
        wr(fbp_pkg::FBP_IDX_TBN, 16'h0005);
        hsize <= 3'h2;
        rd(fbp_pkg::FBP_IDX_TBN, 32'h0);
        for (int n = 0; n < 60; n++) begin
            b = {$random(seed)} % NB;
            c = {$random(seed)} % 5;
            slow <= 1'($random(seed));
            issue(b, cmds[c]);
            c = {$random(seed)} % NB;
            wr(fbp_pkg::FBP_IDX_FBN, 16'(c));
            rd(fbp_pkg::FBP_IDX_WPS, wps(lk[c]));
        end
        warm();
        for (int i = 0; i < NB; i++) begin
            wr(fbp_pkg::FBP_IDX_FBN, 16'(i));
            rd(fbp_pkg::FBP_IDX_WPS, wps(lk[i]));
        end
        slow <= 1'b1;
        issue(1, fbp_pkg::FBP_CMD_UNLOCK);
        op_q.push_back(32'h11);
        op_q.push_back(32'h20);
        wr(fbp_pkg::FBP_IDX_CMD, fbp_pkg::FBP_CMD_PROG);
        wr(fbp_pkg::FBP_IDX_CMD, fbp_pkg::FBP_CMD_CORE);
        rd(fbp_pkg::FBP_IDX_CTRL, BOOTED);
        rd(fbp_pkg::FBP_IDX_TBN, 32'h1);
        rd(fbp_pkg::FBP_IDX_CMD, {16'h0, fbp_pkg::FBP_CMD_CORE});
        op_q.push_back(32'h11);
        op_q.push_back(32'h20);
        wr(fbp_pkg::FBP_IDX_CMD, fbp_pkg::FBP_CMD_PROG);
        warm();
        wr(fbp_pkg::FBP_IDX_FBN, 16'h0001);
        rd(fbp_pkg::FBP_IDX_WPS, 32'h2);
        repeat (4) @(posedge clk);
        tally("pending notes", 32'h0, 32'(rd_q.size() + bt_q.size() + op_q.size()));
        give_verdict();
    end
endmodule : fbp_top_tb_top
`default_nettype wire

// *** verilog/fbp_boot_copy.sv ***
// power-up copy of the boot image from the array into the boot buffer
`timescale 1ns/1ns
`default_nettype none
module fbp_boot_copy #(
    parameter int WORDS = fbp_pkg::FBP_BOOT_WORDS,
    parameter int AW    = fbp_pkg::FBP_BOOT_AW
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic [15:0]   rd_data,
    output var  logic          rd_en_r,
    output var  logic [AW-1:0] rd_addr_r,
    output wire logic          wr_valid,
    output wire logic [AW-1:0] wr_addr,
    output wire logic [15:0]   wr_data,
    output var  logic          done_r
);
    logic [AW:0]   cnt_r;
    logic          pend_r;
    logic [AW-1:0] pend_addr_r;

    // array data answers in the cycle after the read strobe
    assign wr_valid = pend_r;
    assign wr_addr  = pend_addr_r;
    assign wr_data  = rd_data;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r       <= '0;
            rd_en_r     <= 1'b0;
            rd_addr_r   <= '0;
            pend_r      <= 1'b0;
            pend_addr_r <= '0;
            done_r      <= 1'b0;
        end else begin
            pend_r      <= rd_en_r;
            pend_addr_r <= rd_addr_r;
            rd_en_r     <= (cnt_r < (AW+1)'(WORDS));
            if (cnt_r < (AW+1)'(WORDS)) begin
                rd_addr_r <= cnt_r[AW-1:0];
                cnt_r     <= cnt_r + (AW+1)'(1);
            end
            // done never falls until the next power-up reset
            if (pend_r && pend_addr_r == AW'(WORDS - 1)) begin
                done_r <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    copy_len_a: assert property (pend_r && pend_addr_r == AW'(WORDS - 1) |=> done_r)
        else $error("boot copy did not finish after last word");
    done_stay_a: assert property (done_r |=> done_r)
        else $error("boot lock released");
endmodule : fbp_boot_copy
`default_nettype wire

// *** verilog/fbp_pkg.sv ***
// constants and types shared by the block lock protection design
package fbp_pkg;
    // ---------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [15:0] FBP_IDX_FBN  = 16'hF100;
    localparam logic [15:0] FBP_IDX_CMD  = 16'hF220;
    localparam logic [15:0] FBP_IDX_CTRL = 16'hF240;
    localparam logic [15:0] FBP_IDX_TBN  = 16'hF24C;
    localparam logic [15:0] FBP_IDX_WPS  = 16'hF24E;
    // ---------------------------------------------------------------
    // command codes
    // ---------------------------------------------------------------
    localparam logic [15:0] FBP_CMD_LOCK   = 16'h002A;
    localparam logic [15:0] FBP_CMD_TIGHT  = 16'h002C;
    localparam logic [15:0] FBP_CMD_UNLOCK = 16'h0031;
    localparam logic [15:0] FBP_CMD_PROG   = 16'h0041;
    localparam logic [15:0] FBP_CMD_ERASE  = 16'h0042;
    localparam logic [15:0] FBP_CMD_CORE   = 16'h0051;
    // ---------------------------------------------------------------
    // protection status encodings and reset values
    // ---------------------------------------------------------------
    localparam logic [2:0]  FBP_WPS_OPEN   = 3'h4;
    localparam logic [2:0]  FBP_WPS_CLOSED = 3'h2;
    localparam logic [2:0]  FBP_WPS_SEALED = 3'h1;
    localparam logic [2:0]  FBP_WPS_RST    = FBP_WPS_CLOSED;
    localparam logic [15:0] FBP_REG_RST    = 16'h0000;
    // controller status bit positions
    localparam int          FBP_CS_BUSY    = 0;
    localparam int          FBP_CS_REFUSED = 1;
    localparam int          FBP_CS_BOOT    = 2;
    // ---------------------------------------------------------------
    // boot image
    // ---------------------------------------------------------------
    localparam int          FBP_BOOT_BYTES = 1024;
    localparam int          FBP_BOOT_WORDS = FBP_BOOT_BYTES / 2;
    localparam int          FBP_BOOT_AW    = 9;
    localparam logic        FBP_PIN_IDLE   = 1'h1;

    typedef enum logic [1:0] {
        FBP_UNLOCKED = 2'h0,
        FBP_LOCKED   = 2'h1,
        FBP_TIGHT    = 2'h2
    } fbp_lock_t;
endpackage : fbp_pkg

// *** verilog/fbp_sync3.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module fbp_sync3 (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic pin,
    output var  logic level_r
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // s1_r feeds only s2_r; a change counts once s2_r and s3_r agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_r    <= fbp_pkg::FBP_PIN_IDLE;
            s2_r    <= fbp_pkg::FBP_PIN_IDLE;
            s3_r    <= fbp_pkg::FBP_PIN_IDLE;
            level_r <= fbp_pkg::FBP_PIN_IDLE;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end
endmodule : fbp_sync3
`default_nettype wire

// *** verilog/fbp_top.sv ***
// block lock protection with an ahb-lite register slave
`timescale 1ns/1ns
`default_nettype none
module fbp_top #(
    parameter int NUM_BLOCKS = 512,
    parameter int BW         = $clog2(NUM_BLOCKS),
    parameter int AW         = fbp_pkg::FBP_BOOT_AW
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          hardware_reset_n,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output wire logic [31:0]   hrdata,
    output wire logic          hreadyout,
    output wire logic          hresp,
    output wire logic          arr_prog,
    output wire logic          arr_erase,
    output wire logic [BW-1:0] arr_blk,
    output wire logic          arr_abort,
    input  wire logic          arr_op_done,
    output wire logic          arr_rd_en,
    output wire logic [AW-1:0] arr_rd_addr,
    input  wire logic [15:0]   arr_rd_data,
    output wire logic          boot_we,
    output wire logic [AW-1:0] boot_addr,
    output wire logic [15:0]   boot_wdata
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    fbp_pkg::fbp_lock_t lock_r [NUM_BLOCKS];
    logic [15:0]        fbn_r;
    logic [15:0]        cmd_r;
    logic [15:0]        tbn_r;
    logic [2:0]         status_r;
    logic               refresh_r;
    logic               busy_r;
    logic               prog_r;
    logic               erase_r;
    logic [BW-1:0]      blk_r;
    logic               abort_r;
    logic               refused_r;
    logic               dph_wr_r;
    logic [15:0]        dph_idx_r;
    logic [31:0]        hrdata_r;
    logic               hready_r;
    logic               boot_we_r;
    logic [AW-1:0]      boot_addr_r;
    logic [15:0]        boot_wdata_r;
    logic               hw_lvl;
    logic               boot_done;
    logic               ld_valid;
    logic [AW-1:0]      ld_addr;
    logic [15:0]        ld_data;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    fbp_sync3 u_sync (
        .clk     (clk),
        .rstn    (rstn),
        .pin     (hardware_reset_n),
        .level_r (hw_lvl)
    );

    fbp_boot_copy #(.WORDS(fbp_pkg::FBP_BOOT_WORDS), .AW(AW)) u_boot (
        .clk       (clk),
        .rstn      (rstn),
        .rd_data   (arr_rd_data),
        .rd_en_r   (arr_rd_en),
        .rd_addr_r (arr_rd_addr),
        .wr_valid  (ld_valid),
        .wr_addr   (ld_addr),
        .wr_data   (ld_data),
        .done_r    (boot_done)
    );

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire         warm_q   = !hw_lvl;
    wire         addr_ok  = hsel && htrans[1] && hready;
    wire         addr_wr  = addr_ok && hwrite && (hsize == 3'h2);
    wire  [15:0] a_idx    = haddr[17:2];
    wire         wr_fbn   = dph_wr_r && dph_idx_r == fbp_pkg::FBP_IDX_FBN;
    wire         wr_cmd   = dph_wr_r && dph_idx_r == fbp_pkg::FBP_IDX_CMD;
    wire         wr_tbn   = dph_wr_r && dph_idx_r == fbp_pkg::FBP_IDX_TBN;
    wire         wr_boot  = dph_wr_r && dph_idx_r[15:AW] == '0;
    wire  [15:0] cmd_val  = hwdata[15:0];

    // ---------------------------------------------------------------
    // lock decisions
    // ---------------------------------------------------------------
    wire [BW-1:0] tbn_idx = tbn_r[BW-1:0];
    wire [BW-1:0] fbn_idx = fbn_r[BW-1:0];
    wire          tbn_ok  = tbn_r < 16'(NUM_BLOCKS);
    wire          fbn_ok  = fbn_r < 16'(NUM_BLOCKS);
    fbp_pkg::fbp_lock_t cur_st;
    fbp_pkg::fbp_lock_t fbn_st;
    fbp_pkg::fbp_lock_t lock_nxt;
    assign cur_st = lock_r[tbn_idx];
    assign fbn_st = lock_r[fbn_idx];

    wire is_lock   = cmd_val == fbp_pkg::FBP_CMD_LOCK;
    wire is_tight  = cmd_val == fbp_pkg::FBP_CMD_TIGHT;
    wire is_unlock = cmd_val == fbp_pkg::FBP_CMD_UNLOCK;
    wire is_op     = cmd_val == fbp_pkg::FBP_CMD_PROG || cmd_val == fbp_pkg::FBP_CMD_ERASE;
    wire is_core   = cmd_val == fbp_pkg::FBP_CMD_CORE;
    wire wp_hit    = wr_cmd && (is_lock || is_tight || is_unlock) && tbn_ok;

    // tight blocks only leave through reset; tight only from locked
    assign lock_nxt =
        (is_unlock && cur_st == fbp_pkg::FBP_LOCKED) ? fbp_pkg::FBP_UNLOCKED :
        (is_lock   && cur_st != fbp_pkg::FBP_TIGHT)  ? fbp_pkg::FBP_LOCKED :
        (is_tight  && cur_st == fbp_pkg::FBP_LOCKED) ? fbp_pkg::FBP_TIGHT :
        cur_st;

    wire       op_go   = wr_cmd && is_op && !busy_r && !warm_q;
    wire       op_ok   = op_go && tbn_ok && cur_st == fbp_pkg::FBP_UNLOCKED;
    wire       op_end  = arr_op_done || warm_q || (wr_cmd && is_core);
    wire       abt_nxt = busy_r && (warm_q || (wr_cmd && is_core));
    wire [2:0] shown   = !fbn_ok                        ? fbp_pkg::FBP_WPS_CLOSED :
                         fbn_st == fbp_pkg::FBP_UNLOCKED ? fbp_pkg::FBP_WPS_OPEN :
                         fbn_st == fbp_pkg::FBP_TIGHT    ? fbp_pkg::FBP_WPS_SEALED :
                         fbp_pkg::FBP_WPS_CLOSED;

    wire [31:0] ctrl_rd = {29'h0, boot_done, refused_r, busy_r};
    wire [31:0] rd_mux  =
        (a_idx == fbp_pkg::FBP_IDX_FBN)  ? {16'h0000, fbn_r} :
        (a_idx == fbp_pkg::FBP_IDX_CMD)  ? {16'h0000, cmd_r} :
        (a_idx == fbp_pkg::FBP_IDX_CTRL) ? ctrl_rd :
        (a_idx == fbp_pkg::FBP_IDX_TBN)  ? {16'h0000, tbn_r} :
        (a_idx == fbp_pkg::FBP_IDX_WPS)  ? {29'h0, status_r} : 32'h0;

    // loader owns the buffer port; boot writes are dropped once copied
    wire boot_host = wr_boot && !boot_done && !ld_valid;

    // ---------------------------------------------------------------
    // per-block protection state
    // ---------------------------------------------------------------
    for (genvar gi = 0; gi < NUM_BLOCKS; gi++) begin : g_blk
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                lock_r[gi] <= fbp_pkg::FBP_LOCKED;
            end else if (warm_q) begin
                lock_r[gi] <= fbp_pkg::FBP_LOCKED;
            end else if (wp_hit && tbn_idx == BW'(gi)) begin
                lock_r[gi] <= lock_nxt;
            end
        end
    end

    // ---------------------------------------------------------------
    // bus slave and registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dph_wr_r  <= 1'b0;
            dph_idx_r <= '0;
            hrdata_r  <= 32'h0;
            hready_r  <= 1'b1;
        end else begin
            dph_wr_r  <= addr_wr;
            dph_idx_r <= a_idx;
            hready_r  <= 1'b1;
            // read data is taken in the address phase, so a read straight
            // after a write to the same register returns the old value
            if (addr_ok && !hwrite) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    // a core reset command only lands in cmd_r; fbn_r and tbn_r keep their values
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fbn_r <= fbp_pkg::FBP_REG_RST;
            cmd_r <= fbp_pkg::FBP_REG_RST;
            tbn_r <= fbp_pkg::FBP_REG_RST;
        end else if (warm_q) begin
            fbn_r <= fbp_pkg::FBP_REG_RST;
            cmd_r <= fbp_pkg::FBP_REG_RST;
            tbn_r <= fbp_pkg::FBP_REG_RST;
        end else begin
            if (wr_fbn) begin
                fbn_r <= hwdata[15:0];
            end
            if (wr_cmd) begin
                cmd_r <= cmd_val;
            end
            if (wr_tbn) begin
                tbn_r <= hwdata[15:0];
            end
        end
    end

    // status is only refreshed, never cleared by a command
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            refresh_r <= 1'b0;
            status_r  <= fbp_pkg::FBP_WPS_RST;
        end else if (warm_q) begin
            refresh_r <= 1'b0;
            status_r  <= fbp_pkg::FBP_WPS_RST;
        end else begin
            refresh_r <= wr_fbn || wp_hit;
            if (refresh_r) begin
                status_r <= shown;
            end
        end
    end

    // ---------------------------------------------------------------
    // array operation gate
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_r    <= 1'b0;
            prog_r    <= 1'b0;
            erase_r   <= 1'b0;
            blk_r     <= '0;
            abort_r   <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            abort_r <= abt_nxt;
            if (op_ok) begin
                busy_r    <= 1'b1;
                prog_r    <= cmd_val == fbp_pkg::FBP_CMD_PROG;
                erase_r   <= cmd_val == fbp_pkg::FBP_CMD_ERASE;
                blk_r     <= tbn_idx;
                refused_r <= 1'b0;
            end else if (busy_r && op_end) begin
                busy_r  <= 1'b0;
                prog_r  <= 1'b0;
                erase_r <= 1'b0;
            end
            if (op_go && !op_ok) begin
                refused_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            boot_we_r    <= 1'b0;
            boot_addr_r  <= '0;
            boot_wdata_r <= 16'h0000;
        end else begin
            boot_we_r    <= ld_valid || boot_host;
            boot_addr_r  <= ld_valid ? ld_addr : dph_idx_r[AW-1:0];
            boot_wdata_r <= ld_valid ? ld_data : hwdata[15:0];
        end
    end

    assign hrdata     = hrdata_r;
    assign hreadyout  = hready_r;
    assign hresp      = 1'b0 & hready_r;
    assign arr_prog   = prog_r;
    assign arr_erase  = erase_r;
    assign arr_blk    = blk_r;
    assign arr_abort  = abort_r;
    assign boot_we    = boot_we_r;
    assign boot_addr  = boot_addr_r;
    assign boot_wdata = boot_wdata_r;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence fbn_write_s;
        wr_fbn && !warm_q ##1 !warm_q;
    endsequence

    lock_cmd_a: assert property (wp_hit && is_lock && !warm_q
        && cur_st == fbp_pkg::FBP_UNLOCKED |=> lock_r[$past(tbn_idx)] == fbp_pkg::FBP_LOCKED)
        else $error("lock command did not lock block");
    unlock_cmd_a: assert property (wp_hit && is_unlock && !warm_q
        && cur_st == fbp_pkg::FBP_LOCKED |=> lock_r[$past(tbn_idx)] == fbp_pkg::FBP_UNLOCKED)
        else $error("unlock command did not unlock block");
    tight_hold_a: assert property (cur_st == fbp_pkg::FBP_TIGHT && !warm_q
        |=> lock_r[$past(tbn_idx)] == fbp_pkg::FBP_TIGHT)
        else $error("locked-tight block changed");
    no_direct_tight_a: assert property (wp_hit && is_tight && !warm_q
        && cur_st == fbp_pkg::FBP_UNLOCKED |=> lock_r[$past(tbn_idx)] == fbp_pkg::FBP_UNLOCKED)
        else $error("unlocked block went locked-tight");
    warm_lock_a: assert property (warm_q |=> cur_st == fbp_pkg::FBP_LOCKED
        && status_r == fbp_pkg::FBP_WPS_CLOSED)
        else $error("warm reset left block unlocked");
    status_onehot_a: assert property ($onehot(status_r))
        else $error("status not one-hot");
    fbn_refresh_a: assert property (fbn_write_s |=> status_r == $past(shown))
        else $error("status not refreshed after block number write");
    status_keep_a: assert property (!refresh_r && !warm_q |=> $stable(status_r))
        else $error("status changed without refresh");
    op_refuse_a: assert property (op_go && cur_st != fbp_pkg::FBP_UNLOCKED
        |=> !arr_prog && !arr_erase && refused_r)
        else $error("locked block operation started");
    op_start_a: assert property (op_ok |=> busy_r && arr_blk == $past(tbn_idx))
        else $error("unlocked block operation not started");
    core_abort_a: assert property (wr_cmd && is_core && busy_r
        |=> arr_abort && !busy_r ##1 !arr_abort)
        else $error("core reset did not abort");
    core_keep_a: assert property (wr_cmd && is_core && !warm_q && !refresh_r
        |=> $stable(fbn_r) && $stable(tbn_r) && $stable(status_r))
        else $error("core reset changed registers");
    boot_lock_a: assert property (boot_done && !ld_valid |=> !boot_we)
        else $error("boot buffer written after copy");
endmodule : fbp_top
`default_nettype wire
